// file: dv/aircc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module aircc_analog_model (
  input  wire logic [4:0] sar_channel,
  input  wire logic       sar_differential,
  input  wire logic       ref_supply,
  input  wire logic       ref_internal,
  input  wire logic       over_req,
  output logic      [9:0] sar_code,
  output logic            sar_over_range
);
  // For single-ended channels the code carries reference and channel, so a stale selection shows.
  always_comb begin
    sar_code = {ref_internal, ref_internal | ref_supply, 3'h0, sar_channel};
    if (sar_differential) begin
      sar_code = 10'h3a3;
    end
    sar_over_range = over_req;
  end
endmodule
`default_nettype wire

// file: dv/aircc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module aircc_monitor (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic [4:0] sar_channel,
  input wire logic       sar_differential,
  input wire logic       ref_ext_pin,
  input wire logic       ref_supply,
  input wire logic       ref_internal
);
  logic clr_ev;
  assign clr_ev = (reg_rd && reg_addr == 3'h4) || (reg_wr && reg_addr == 3'h5);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_sel_wr;
    reg_wr && reg_addr == 3'h0;
  endsequence
  sequence s_trig_wr;
    reg_wr && reg_addr == 3'h1 && reg_wdata[7] && reg_wdata[6];
  endsequence
  a_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
  a_unmapped_read:
    assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_ref_exclusive:
    assert property ($onehot0({ref_ext_pin, ref_supply, ref_internal})) else $error("two refs");
  a_diff_map:
    assert property (sar_differential == (sar_channel inside {[5'h08:5'h1d]}))
      else $error("differential flag wrong");
  a_mask_quiet:
    assert property (reg_wr && reg_addr == 3'h5 && !reg_wdata[0] |-> ##2 !irq)
      else $error("irq while masked");
  a_irq_holds:
    assert property (irq && !clr_ev && !$past(clr_ev) && !$past(clr_ev, 2) |=> irq)
      else $error("irq dropped");
  a_sel_readback:
    assert property (s_sel_wr ##2 (reg_rd && reg_addr == 3'h0) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("select readback");
  a_busy_shown:
    assert property (s_trig_wr ##2 (reg_rd && reg_addr == 3'h1) |=> reg_rdata[6])
      else $error("busy not shown");
endmodule
bind aircc_top aircc_monitor u_mon (.*);
`default_nettype wire

// file: dv/tb_adc_input_result_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_input_result_control;
  import aircc_pkg::*;
  logic mclk, reset, reg_wr, reg_rd, irq, sleep_noise_mode, cpu_halted, sar_over_range;
  logic sar_differential, ref_ext_pin, ref_supply, ref_internal, sar_sample, over_req;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [9:0] sar_code;
  logic [4:0] sar_channel;
  int         n_fail, checks;
  logic [8:0] cases [8] = '{9'h043, 9'h05f, 9'h0e6, 9'h0de, 9'h0fb, 9'h07b, 9'h102, 9'h159};
  aircc_top DUT (.*);
  aircc_analog_model u_ana (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [15:0] exp_pair(input logic [7:0] s, input logic ov);
    logic dif;
    logic [9:0] r;
    dif = s[4:0] inside {[5'h08:5'h1d]};
    r = dif ? 10'h3a3 : {s[7:6], 3'h0, s[4:0]};
    if (ov) r = dif ? (r[9] ? 10'h200 : 10'h1ff) : 10'h3ff;
    if (s[4:0] == 5'h1f) r = 10'h000;
    return s[5] ? {r, 6'h00} : {6'h00, r};
  endfunction
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic pair_is(input logic [7:0] s, input logic ov);
    logic [7:0] hi, lo;
    rd(3'h3, hi);
    rd(3'h2, lo);
    chk({hi, lo}, exp_pair(s, ov));
  endtask
  // Sampling on the falling edge keeps the poll clear of the update race.
  task automatic wait_irq();
    for (int i = 0; i < 80 && irq !== 1'b1; i++) @(negedge mclk);
    if (irq !== 1'b1) begin
      n_fail++;
      final_report();
    end
    rd(3'h4, v);
    chk(v[0], 1'b1);
  endtask
  task automatic t_single(input logic [7:0] s, input logic ov);
    over_req <= ov;
    wr(3'h0, s);
    rd(3'h0, v);
    chk(v, s);
    wr(3'h5, 8'h01);
    wr(3'h1, 8'hc0);
    rd(3'h1, v);
    chk(v[6], 1'b1);
    wait_irq();
    pair_is(s, ov);
    wr(3'h0, s ^ 8'h20);
    pair_is(s ^ 8'h20, ov);
    wr(3'h1, 8'h00);
  endtask
  task automatic t_free();
    over_req <= 1'b0;
    wr(3'h0, 8'h42);
    wr(3'h1, 8'he0);
    wait_irq();
    wr(3'h0, 8'hc5);
    wait_irq();
    pair_is(8'h42, 1'b0);
    wait_irq();
    pair_is(8'hc5, 1'b0);
    wr(3'h1, 8'h00);
    $display("free run done");
  endtask
  task automatic t_sleep(input logic mode, input logic early);
    wr(3'h0, 8'h44);
    wr(3'h1, 8'h80);
    sleep_noise_mode <= mode;
    cpu_halted <= 1'b1;
    repeat (8) @(posedge mclk);
    cpu_halted <= !early;
    if (mode) begin
      wait_irq();
      pair_is(8'h44, 1'b0);
    end else begin
      repeat (40) @(negedge mclk);
      chk(irq, 1'b0);
      rd(3'h1, v);
      chk(v[7], 1'b1);
    end
    sleep_noise_mode <= 1'b0;
    cpu_halted <= 1'b0;
    wr(3'h1, 8'h00);
    $display("sleep done");
  endtask
  task automatic t_mask();
    wr(3'h5, 8'h00);
    wr(3'h1, 8'hc0);
    repeat (40) @(negedge mclk);
    chk(irq, 1'b0);
    wr(3'h5, 8'h01);
    repeat (3) @(negedge mclk);
    chk(irq, 1'b1);
    wait_irq();
    repeat (3) @(negedge mclk);
    chk(irq, 1'b0);
    $display("mask done");
  endtask
  initial begin
    {reset, reg_wr, reg_rd, sleep_noise_mode, cpu_halted, over_req} = 6'h20;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rd(3'h0, v);
    chk(v, 8'h00);
    wr(3'h7, 8'hff);
    rd(3'h7, v);
    chk(v, 8'h00);
    foreach (cases[i]) t_single(cases[i][7:0], cases[i][8]);
    $display("single done");
    t_free();
    t_sleep(1'b1, 1'b0);
    t_sleep(1'b1, 1'b1);
    t_sleep(1'b0, 1'b0);
    t_mask();
    final_report();
  end
endmodule
`default_nettype wire

// file: hw/aircc_cfg.svh
// Notes on behaviour
// - Running conversion keeps old channel in free run.
// - Input above reference saturates to full code.
// - Reference field picks pin, supply, reserved, internal.
// - Reference write waits until conversion completes.
// - Sleep with prerequisites starts conversion automatically.
// - Completion raises interrupt even after earlier wake.
// - Other sleep modes leave converter running.
// - Single-ended result is unsigned ten-bit code.
// - Differential result is two's complement ten-bit.
// - Align bit changes result view immediately.
// - Result registers hold completed conversion.
// - Done flag set after result registers update.
// - Channel codes map inputs, differential, bandgap, ground.
// - Left align puts bits 9:2 high byte.
`ifndef AIRCC_CFG_SVH
`define AIRCC_CFG_SVH
`define AIRCC_ADDR_SELECT   3'h0
`define AIRCC_ADDR_CONTROL  3'h1
`define AIRCC_ADDR_RES_LOW  3'h2
`define AIRCC_ADDR_RES_HIGH 3'h3
`define AIRCC_ADDR_STATUS   3'h4
`define AIRCC_ADDR_MASK     3'h5
`define AIRCC_SELECT_RESET  8'h00
`define AIRCC_CTRL_ON       7
`define AIRCC_CTRL_TRIG     6
`define AIRCC_CTRL_FREE     5
`define AIRCC_SEL_ALIGN     5
`define AIRCC_CONV_CYCLES   5'h0d
`define AIRCC_FIRST_CYCLES  5'h19
`define AIRCC_CODE_MAX      10'h3ff
`define AIRCC_DIFF_MAX      10'h1ff
`define AIRCC_DIFF_MIN      10'h200
`define AIRCC_CH_BANDGAP    5'h1e
`define AIRCC_CH_GROUND     5'h1f
`define AIRCC_CH_SE_LAST    5'h07
`endif

// file: hw/aircc_pkg.sv
package aircc_pkg;
  typedef enum logic [1:0] {
    AIRCC_IDLE = 2'b00,
    AIRCC_CONV = 2'b01,
    AIRCC_DONE = 2'b11
  } aircc_state_e;
  typedef enum logic [1:0] {
    AIRCC_REF_PIN      = 2'b00,
    AIRCC_REF_SUPPLY   = 2'b01,
    AIRCC_REF_RESERVED = 2'b10,
    AIRCC_REF_INTERNAL = 2'b11
  } aircc_ref_e;
endpackage

// file: hw/aircc_top.sv
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "aircc_cfg.svh"
module aircc_top
  import aircc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  output var  logic       irq,
  input  wire logic       sleep_noise_mode,
  input  wire logic       cpu_halted,
  input  wire logic [9:0] sar_code,
  input  wire logic       sar_over_range,
  output var  logic [4:0] sar_channel,
  output var  logic       sar_differential,
  output var  logic       ref_ext_pin,
  output var  logic       ref_supply,
  output var  logic       ref_internal,
  output var  logic       sar_sample
);

  // Pin-side inputs pass two flip-flops before use.
  logic [1:0]   sleep_sync_r;
  logic [1:0]   halt_sync_r;
  logic [10:0]  code_sync1_r;
  logic [10:0]  code_sync2_r;
  logic [7:0]   select_r;
  logic         conv_on_r;
  logic         trigger_r;
  logic         free_run_r;
  logic         first_pending_r;
  logic         done_flag_r;
  logic         mask_r;
  logic [4:0]   cnt_r;
  logic [9:0]   result_r;
  logic [7:0]   locked_sel_r;
  logic         sleep_armed_r;
  aircc_state_e state_r;
  aircc_state_e state_nxt;
  logic         start_req;
  logic         complete;
  logic [9:0]   raw_code;
  logic [7:0]   res_low;
  logic [7:0]   res_high;
  logic         status_rd;
  logic         sel_wr;
  logic         ctl_wr;
  logic         mask_wr;
  logic         trig_wr;
  logic         entering;
  logic [7:0]   read_word;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sleep_sync_r <= 2'h0;
    end else begin
      sleep_sync_r <= {sleep_sync_r[0], sleep_noise_mode};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      halt_sync_r <= 2'h0;
    end else begin
      halt_sync_r <= {halt_sync_r[0], cpu_halted};
    end
  end

  // The converter word can only move in the first cycles of a conversion and then holds, so sampling it bit by bit is safe.
  // A word that moved near the end of a conversion would be caught half old, half new.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      code_sync1_r <= 11'h000;
      code_sync2_r <= 11'h000;
    end else begin
      code_sync1_r <= {sar_over_range, sar_code};
      code_sync2_r <= code_sync1_r;
    end
  end

  // Sleep start fires once per sleep entry, only when the converter is on and idle.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sleep_armed_r <= 1'b1;
    end else if (!(sleep_sync_r[1] && halt_sync_r[1])) begin
      sleep_armed_r <= 1'b1;
    end else if (state_r == AIRCC_CONV) begin
      sleep_armed_r <= 1'b0;
    end
  end

  assign start_req = conv_on_r && (trigger_r
                     || (sleep_armed_r && sleep_sync_r[1] && halt_sync_r[1] && !free_run_r));
  assign complete  = (state_r == AIRCC_CONV) && (cnt_r == 5'h01);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      AIRCC_IDLE: begin
        if (start_req) state_nxt = AIRCC_CONV;
      end
      AIRCC_CONV: begin
        if (!conv_on_r) state_nxt = AIRCC_IDLE;
        else if (complete) state_nxt = AIRCC_DONE;
      end
      AIRCC_DONE: begin
        if (free_run_r && conv_on_r) begin
          state_nxt = AIRCC_CONV;
        end else begin
          state_nxt = AIRCC_IDLE;
        end
      end
      default: begin
        state_nxt = AIRCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= AIRCC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Cycle counter; the first conversion after switching on runs long.
  assign entering = (state_r != AIRCC_CONV) && (state_nxt == AIRCC_CONV);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_r <= 5'h00;
    end else if (entering) begin
      cnt_r <= first_pending_r ? `AIRCC_FIRST_CYCLES : `AIRCC_CONV_CYCLES;
    end else if (state_r == AIRCC_CONV && cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // Switching off re-arms the long first conversion, even when it cut one short.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      first_pending_r <= 1'b1;
    end else if (!conv_on_r) begin
      first_pending_r <= 1'b1;
    end else if (entering) begin
      first_pending_r <= 1'b0;
    end
  end

  // Selection is copied to the converter only outside a conversion, so a write mid-conversion
  // lands on the next one; in free run the conversion already started keeps the old channel.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      locked_sel_r <= `AIRCC_SELECT_RESET;
    end else if (state_nxt != AIRCC_CONV || state_r != AIRCC_CONV) begin
      if (state_r != AIRCC_CONV) begin
        locked_sel_r <= select_r;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sar_channel <= 5'h00;
    end else begin
      sar_channel <= locked_sel_r[4:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sar_differential <= 1'b0;
    end else begin
      sar_differential <= (locked_sel_r[4:0] > `AIRCC_CH_SE_LAST)
                          && (locked_sel_r[4:0] < `AIRCC_CH_BANDGAP);
    end
  end

  // The reserved reference code drives no switch at all, so nothing is shorted.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ref_ext_pin <= 1'b0;
    end else begin
      ref_ext_pin <= aircc_ref_e'(locked_sel_r[7:6]) == AIRCC_REF_PIN;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ref_supply <= 1'b0;
    end else begin
      ref_supply <= aircc_ref_e'(locked_sel_r[7:6]) == AIRCC_REF_SUPPLY;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ref_internal <= 1'b0;
    end else begin
      ref_internal <= aircc_ref_e'(locked_sel_r[7:6]) == AIRCC_REF_INTERNAL;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sar_sample <= 1'b0;
    end else begin
      sar_sample <= state_r == AIRCC_CONV;
    end
  end

  // Coding of the raw converter word into the stored result.
  always_comb begin
    raw_code = code_sync2_r[9:0];
    if (locked_sel_r[4:0] == `AIRCC_CH_GROUND) begin
      raw_code = 10'h000;
    end else if (code_sync2_r[10]) begin
      if (sar_differential) begin
        raw_code = code_sync2_r[9] ? `AIRCC_DIFF_MIN : `AIRCC_DIFF_MAX;
      end else begin
        raw_code = `AIRCC_CODE_MAX;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      result_r <= 10'h000;
    end else if (complete) begin
      result_r <= raw_code;
    end
  end

  // The done flag rises the cycle after the result write; a read of the status clears it, set wins.
  assign status_rd = reg_rd && reg_addr == `AIRCC_ADDR_STATUS;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      done_flag_r <= 1'b0;
    end else if (state_r == AIRCC_DONE) begin
      done_flag_r <= 1'b1;
    end else if (status_rd) begin
      done_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (done_flag_r || state_r == AIRCC_DONE) && mask_r;
    end
  end

  // Software registers. Sleep modes never clear the enable bit, only software does.
  assign sel_wr  = reg_wr && reg_addr == `AIRCC_ADDR_SELECT;
  assign ctl_wr  = reg_wr && reg_addr == `AIRCC_ADDR_CONTROL;
  assign mask_wr = reg_wr && reg_addr == `AIRCC_ADDR_MASK;
  assign trig_wr = ctl_wr && reg_wdata[`AIRCC_CTRL_TRIG] && reg_wdata[`AIRCC_CTRL_ON];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      select_r <= `AIRCC_SELECT_RESET;
    end else if (sel_wr) begin
      select_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      conv_on_r <= 1'b0;
    end else if (ctl_wr) begin
      conv_on_r <= reg_wdata[`AIRCC_CTRL_ON];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      free_run_r <= 1'b0;
    end else if (ctl_wr) begin
      free_run_r <= reg_wdata[`AIRCC_CTRL_FREE];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mask_r <= 1'b0;
    end else if (mask_wr) begin
      mask_r <= reg_wdata[0];
    end
  end

  // Trigger bit reads one while converting; writing zero does nothing.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      trigger_r <= 1'b0;
    end else if (trig_wr) begin
      trigger_r <= 1'b1;
    end else if (!conv_on_r || (state_r == AIRCC_DONE && !free_run_r)) begin
      trigger_r <= 1'b0;
    end
  end

  // The alignment bit is applied at read time, so it acts at once even mid-conversion.
  always_comb begin
    if (select_r[`AIRCC_SEL_ALIGN]) begin
      res_high = result_r[9:2];
      res_low  = {result_r[1:0], 6'h00};
    end else begin
      res_high = {6'h00, result_r[9:8]};
      res_low  = result_r[7:0];
    end
  end

  // Unmapped addresses read zero, so software probing the space sees nothing stray.
  always_comb begin
    unique case (reg_addr)
      `AIRCC_ADDR_SELECT:   read_word = select_r;
      `AIRCC_ADDR_CONTROL:  read_word = {conv_on_r, trigger_r || state_r != AIRCC_IDLE,
                                         free_run_r, 5'h00};
      `AIRCC_ADDR_RES_LOW:  read_word = res_low;
      `AIRCC_ADDR_RES_HIGH: read_word = res_high;
      `AIRCC_ADDR_STATUS:   read_word = {7'h00, done_flag_r};
      `AIRCC_ADDR_MASK:     read_word = {7'h00, mask_r};
      default:              read_word = 8'h00;
    endcase
  end

  // Read data stand for one cycle only and fall back to zero.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_word;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire
